// *** pend_pkg.sv ***
// Constants shared by the pending set/clear controller files
package pend_pkg;
	localparam int NUM_IRQ = 50;
	localparam int LO_W = 32;
	localparam int UP_W = 18;
	localparam int EV_W = 3;
	localparam int ADR_W = 8;

	// Byte offsets of the word registers
	localparam logic [7:0] SET_LO_OFF = 8'h00;
	localparam logic [7:0] SET_HI_OFF = 8'h04;
	localparam logic [7:0] CLR_LO_OFF = 8'h08;
	localparam logic [7:0] CLR_HI_OFF = 8'h0C;
	localparam logic [7:0] EV_STAT_OFF = 8'h10;
	localparam logic [7:0] EV_CLR_OFF = 8'h14;
	localparam logic [7:0] EV_EN_OFF = 8'h18;

	// Event bit positions in status, clear and enable
	localparam int EV_NEW_PEND = 0;
	localparam int EV_SET_IGN = 1;
	localparam int EV_CLR_REF = 2;

	// Reset values
	localparam logic [49:0] PEND_RST = 50'h0;
	localparam logic [2:0] EV_STAT_RST = 3'h0;
	localparam logic [2:0] EV_EN_RST = 3'h0;
	localparam logic [31:0] RD_ZERO = 32'h0;

	// Bus answer latency in cycles after the request is seen
	localparam int ACK_LAT = 1;
endpackage : pend_pkg

// *** pend_if.sv ***
// Signals between the bus front end and the pending flag bank
`timescale 1ns/1ns
interface pend_if;
	logic [49:0] sw_set;
	logic [49:0] sw_clr;
	logic [49:0] hw_req;
	logic [49:0] enable;
	logic [49:0] active;
	logic [49:0] pending;
	logic set_ign;
	logic clr_ref;
	logic new_pend;

	modport bank (
		input sw_set, sw_clr, hw_req, enable, active,
		output pending, set_ign, clr_ref, new_pend
	);
	modport ctrl (
		output sw_set, sw_clr, hw_req, enable, active,
		input pending, set_ign, clr_ref, new_pend
	);
endinterface : pend_if

// *** pend_bank.sv ***
// One shared pending flag per interrupt line
`timescale 1ns/1ns
module pend_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	pend_if.bank pb
);
	logic [49:0] pend_r;
	wire [49:0] pend_nxt;
	wire [49:0] set_eff;
	wire [49:0] clr_eff;

	genvar i;
	generate
		for (i = 0; i < pend_pkg::NUM_IRQ; i++) begin : g_bit
			// Only an enabled, not yet pending line can be pended
			assign set_eff[i] = (pb.sw_set[i] | pb.hw_req[i]) & pb.enable[i] & ~pend_r[i];
			// Lines in service keep their flag
			assign clr_eff[i] = pb.sw_clr[i] & ~pb.active[i];
			// A request on a pending line is masked, so a clear in the same cycle wins
			assign pend_nxt[i] = set_eff[i] | (pend_r[i] & ~clr_eff[i]);
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_r <= pend_pkg::PEND_RST;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	assign pb.pending = pend_r;
	assign pb.set_ign = |(pb.sw_set & (pend_r | ~pb.enable));
	assign pb.clr_ref = |(pb.sw_clr & pb.active & pend_r);
	assign pb.new_pend = |set_eff;
endmodule : pend_bank

// *** pend_ctrl.sv ***
// Wishbone front end of the interrupt pending set/clear registers
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - A one written to a set bit pends the matching interrupt.
// - A set one on a line already pending or disabled leaves the pending flags as they are but sets event bit EV_SET_IGN.
// - Zero bits written to any set or clear register change nothing.
// - Reading either pending register returns the live pending flags.
// - A one written to a clear bit removes the matching pending flag.
// - A clear one on a line in service keeps its flag, and sets event bit EV_CLR_REF if the line is pending.
// - Set and clear registers show one shared flag per interrupt.
// - Upper set register bits 17..0 map to lines 49..32, the rest read 0.
// - Upper clear register bits 17..0 clear lines 49..32.
//////////////////////////////////////////////////////////////////////////////
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module pend_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [49:0] irq_req_i,
	input wire logic [49:0] irq_en_i,
	input wire logic [49:0] irq_active_i,
	output logic [49:0] pending_o,
	output logic irq_o
);

	//////////////////////////////////////////////////////////////////////////
	// Flag bank

	pend_if pif ();

	pend_bank u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pb(pif.bank)
	);

	logic ack_r;
	logic [31:0] dat_r;
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] ien_r;
	logic [2:0] ien_nxt;
	logic irq_r;

	//////////////////////////////////////////////////////////////////////////
	// Decoding

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction : hit

	function automatic logic [31:0] lanes(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lanes

	wire req = cyc_i & stb_i;
	// Write lands on the edge at which the master sees ack
	wire wr_go = req & we_i & ack_r;
	wire rd_new = req & ~we_i & ~ack_r;
	wire [31:0] wdat = dat_i & lanes(sel_i);

	wire hit_setl = hit(adr_i, pend_pkg::SET_LO_OFF);
	wire hit_seth = hit(adr_i, pend_pkg::SET_HI_OFF);
	wire hit_clrl = hit(adr_i, pend_pkg::CLR_LO_OFF);
	wire hit_clrh = hit(adr_i, pend_pkg::CLR_HI_OFF);
	wire hit_eclr = hit(adr_i, pend_pkg::EV_CLR_OFF);
	wire hit_ien = hit(adr_i, pend_pkg::EV_EN_OFF);

	// Zero bits give zero strobes, so they touch nothing
	wire [31:0] set_lo = {32{wr_go & hit_setl}} & wdat;
	wire [17:0] set_hi = {18{wr_go & hit_seth}} & wdat[17:0];
	wire [31:0] clr_lo = {32{wr_go & hit_clrl}} & wdat;
	wire [17:0] clr_hi = {18{wr_go & hit_clrh}} & wdat[17:0];
	wire [2:0] ev_clr = {3{wr_go & hit_eclr}} & wdat[2:0];

	assign pif.sw_set = {set_hi, set_lo};
	assign pif.sw_clr = {clr_hi, clr_lo};
	assign pif.hw_req = irq_req_i;
	assign pif.enable = irq_en_i;
	assign pif.active = irq_active_i;

	wire [49:0] pend = pif.pending;

	//////////////////////////////////////////////////////////////////////////
	// Read mux

	// Both views of a line come from the one flag
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = pend_pkg::RD_ZERO;
		if (hit(a, pend_pkg::SET_LO_OFF) || hit(a, pend_pkg::CLR_LO_OFF)) begin
			w = pend[31:0];
		end else if (hit(a, pend_pkg::SET_HI_OFF) || hit(a, pend_pkg::CLR_HI_OFF)) begin
			w = {14'h0, pend[49:32]};
		end else if (hit(a, pend_pkg::EV_STAT_OFF)) begin
			w = {29'h0, stat_r};
		end else if (hit(a, pend_pkg::EV_EN_OFF)) begin
			w = {29'h0, ien_r};
		end
		return w;
	endfunction : rd_word

	wire [31:0] rd_mux = rd_word(adr_i);

	//////////////////////////////////////////////////////////////////////////
	// Event status and interrupt

	wire [2:0] ev_in = {pif.clr_ref, pif.set_ign, pif.new_pend};

	// Set wins over a clear in the same cycle
	assign stat_nxt = ev_in | (stat_r & ~ev_clr);
	assign ien_nxt = (wr_go & hit_ien) ? wdat[2:0] : ien_r;

	//////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= pend_pkg::RD_ZERO;
		end else begin
			ack_r <= req & ~ack_r;
			// Data sampled one cycle before the ack edge
			dat_r <= rd_new ? rd_mux : pend_pkg::RD_ZERO;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_r <= pend_pkg::EV_STAT_RST;
			ien_r <= pend_pkg::EV_EN_RST;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			ien_r <= ien_nxt;
			irq_r <= |(stat_nxt & ien_nxt);
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign irq_o = irq_r;
	assign pending_o = pend;

	//////////////////////////////////////////////////////////////////////////
	// Checks

	wire [49:0] hw_set = irq_req_i & irq_en_i;
	wire [49:0] set_ok = pif.sw_set & irq_en_i;
	wire [49:0] set_dead = pif.sw_set & ~irq_en_i & ~pend;
	wire [49:0] clr_ok = pif.sw_clr & ~irq_active_i & ~hw_set;
	wire [49:0] clr_kept = pif.sw_clr & irq_active_i & pend;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence bus_req;
		req && !ack_r;
	endsequence

	sequence rd_of(logic h);
		rd_new && h;
	endsequence

	sequence quiet_write;
		wr_go && (hit_setl || hit_seth || hit_clrl || hit_clrh) && wdat == 32'h0;
	endsequence

	sequence lo_clear;
		wr_go && hit_clrl;
	endsequence

	sequence hi_clear;
		wr_go && hit_clrh;
	endsequence

	property pend_after_set;
		(set_ok != 50'h0) |=> ((pend & $past(set_ok)) == $past(set_ok));
	endproperty

	property dead_set_stays;
		(set_dead != 50'h0) && ((set_dead & hw_set) == 50'h0)
			|=> ((pend & $past(set_dead)) == 50'h0);
	endproperty

	property no_change_on_zero;
		quiet_write ##0 (hw_set == 50'h0) |=> (pend == $past(pend));
	endproperty

	property live_read_lo;
		rd_of(hit_setl || hit_clrl) |=> ack_o && (dat_o == $past(pend[31:0]));
	endproperty

	property cleared_lines;
		(clr_ok != 50'h0) |=> ((pend & $past(clr_ok)) == 50'h0);
	endproperty

	property serviced_kept;
		(clr_kept != 50'h0) |=> ((pend & $past(clr_kept)) == $past(clr_kept));
	endproperty

	property upper_read;
		rd_of(hit_seth) |=> (dat_o[31:18] == 14'h0)
			&& (dat_o[17:0] == $past(pend[49:32]));
	endproperty

	property lower_map;
		lo_clear |=> ((pend[31:0] & $past(wdat & ~irq_active_i[31:0]
			& ~hw_set[31:0])) == 32'h0);
	endproperty

	property upper_clear_map;
		hi_clear |=> ((pend[49:32] & $past(wdat[17:0] & ~irq_active_i[49:32]
			& ~hw_set[49:32])) == 18'h0);
	endproperty

	property ack_shape;
		bus_req |=> ack_o ##1 !ack_o;
	endproperty

	property irq_level;
		##1 (irq_o == |(stat_r & ien_r));
	endproperty

	set_pends_a: assert property (pend_after_set)
		else $error("enabled set bit did not pend");
	set_ignored_a: assert property (dead_set_stays)
		else $error("disabled set bit became pending");
	zero_write_a: assert property (no_change_on_zero)
		else $error("zero write changed pending state");
	live_read_a: assert property (live_read_lo)
		else $error("pending read not live");
	clear_takes_a: assert property (cleared_lines)
		else $error("clear bit did not remove pending");
	service_keep_a: assert property (serviced_kept)
		else $error("clear removed a serviced line");
	// Upper clear view read must show the same flags the upper set view shows
	shared_view_a: assert property (rd_of(hit_clrh) |=> (dat_o[31:18] == 14'h0)
		&& (dat_o[17:0] == $past(pend[49:32])))
		else $error("set and clear views differ");
	upper_map_a: assert property (upper_read)
		else $error("upper set register read wrong");
	lower_clear_a: assert property (lower_map)
		else $error("lower clear mapping wrong");
	upper_clear_a: assert property (upper_clear_map)
		else $error("upper clear mapping wrong");
	bus_ack_a: assert property (ack_shape)
		else $error("ack not a single cycle after request");
	irq_out_a: assert property (irq_level)
		else $error("interrupt output disagrees with status");

endmodule : pend_ctrl

// *** pend_src_model.sv ***
// Behavioural source of request, enable and in-service lines
`timescale 1ns/1ns
module pend_src_model (
	input wire logic clk_i,
	input wire logic [49:0] req_cmd_i,
	input wire logic [49:0] en_cmd_i,
	input wire logic [49:0] act_cmd_i,
	output logic [49:0] irq_req_o,
	output logic [49:0] irq_en_o,
	output logic [49:0] irq_active_o
);
	// Registered so every line changes just after an edge, like core logic
	always_ff @(posedge clk_i) begin
		irq_req_o <= req_cmd_i;
		irq_en_o <= en_cmd_i;
		irq_active_o <= act_cmd_i;
	end
endmodule : pend_src_model

// *** pend_ctrl_tb.sv ***
// Self-checking bench for the pending set/clear register block
`timescale 1ns/1ns
module pend_ctrl_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic ack_o, irq_o;
	logic [49:0] req_c = 50'h0, en_c = 50'h0, act_c = 50'h0;
	logic [49:0] req_w, en_w, act_w, pending_o;
	int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
	//////////////////////////////////////////////////////////////////////////////
	pend_src_model src_u (.clk_i(clk_i), .req_cmd_i(req_c), .en_cmd_i(en_c),
		.act_cmd_i(act_c), .irq_req_o(req_w), .irq_en_o(en_w), .irq_active_o(act_w));
	pend_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.irq_req_i(req_w), .irq_en_i(en_w), .irq_active_i(act_w),
		.pending_o(pending_o), .irq_o(irq_o));
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	// Bus calls can hang on a dead ack, so a cycle ceiling ends the run
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic chk(input logic [49:0] seen, input logic [49:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Entered just after a rising edge; ack and read data are taken at the same edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hF);
		chk({18'h0, rdat}, {18'h0, exp});
	endtask : rd_chk
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(pending_o, 50'h0);
		chk({49'h0, irq_o}, 50'h0);
		en_c <= 50'h3_FFFF_FFFF_FFFF;
		wr(pend_pkg::SET_LO_OFF, 32'h0000_00A5);
		rd_chk(pend_pkg::SET_LO_OFF, 32'h0000_00A5);
		rd_chk(pend_pkg::CLR_LO_OFF, 32'h0000_00A5);
		wr(pend_pkg::SET_HI_OFF, 32'hFFFF_FFFF);
		rd_chk(pend_pkg::SET_HI_OFF, 32'h0003_FFFF);
		chk(pending_o, {18'h3_FFFF, 32'h0000_00A5});
		wr(pend_pkg::CLR_LO_OFF, 32'h0);
		wr(pend_pkg::SET_LO_OFF, 32'h0);
		chk(pending_o, {18'h3_FFFF, 32'h0000_00A5});
		$display("test set and zero writes done");
		act_c <= 50'h4;
		wr(pend_pkg::CLR_LO_OFF, 32'h0000_0005);
		rd_chk(pend_pkg::SET_LO_OFF, 32'h0000_00A4);
		wr(pend_pkg::CLR_HI_OFF, 32'hFFFF_FFFF);
		rd_chk(pend_pkg::CLR_HI_OFF, 32'h0);
		chk(pending_o, {18'h0, 32'h0000_00A4});
		$display("test clear and service done");
		en_c <= 50'h3_FFFF_FFFF_FBFF;
		wr(pend_pkg::SET_LO_OFF, 32'h0000_0404);
		chk(pending_o, {18'h0, 32'h0000_00A4});
		wb(1'b1, pend_pkg::SET_LO_OFF, 32'hFFFF_FFFF, 4'h2);
		rd_chk(pend_pkg::SET_LO_OFF, 32'h0000_FBA4);
		wr(8'h20, 32'hFFFF_FFFF);
		rd_chk(8'h20, 32'h0);
		$display("test disabled, lanes, unmapped done");
		rd_chk(pend_pkg::EV_STAT_OFF, 32'h7);
		chk({49'h0, irq_o}, 50'h0);
		wr(pend_pkg::EV_EN_OFF, 32'h7);
		chk({49'h0, irq_o}, 50'h1);
		wr(pend_pkg::EV_CLR_OFF, 32'h7);
		rd_chk(pend_pkg::EV_STAT_OFF, 32'h0);
		chk({49'h0, irq_o}, 50'h0);
		wr(pend_pkg::EV_EN_OFF, 32'h2);
		wr(pend_pkg::SET_LO_OFF, 32'h0000_0004);
		chk({49'h0, irq_o}, 50'h1);
		wr(pend_pkg::EV_EN_OFF, 32'h0);
		chk({49'h0, irq_o}, 50'h0);
		$display("test event interrupt done");
		req_c <= 50'h100_0000_0000;
		wr(pend_pkg::EV_CLR_OFF, 32'h7);
		req_c <= 50'h0;
		rd_chk(pend_pkg::SET_HI_OFF, 32'h0000_0100);
		wr(pend_pkg::CLR_HI_OFF, 32'h0000_0100);
		rd_chk(pend_pkg::CLR_HI_OFF, 32'h0);
		$display("test hardware request done");
		print_verdict();
	end
endmodule : pend_ctrl_tb
